/* pwmcr_top.sv */
// Compare reload control for a triangular three-phase PWM timer
`include "pwmcr_map.svh"

// Contract
// - Anytime mode: duty rewritten before its match takes effect for that match.
// - A duty value the counter never reaches leaves the positive output unchanged; the code still drives it high at crest and low at valley.
// - Crest drives positive outputs high, valley drives them low, always.
// - After one match in a slope, further matches leave the output alone.
// - An ignored match still raises that phase's match interrupt.
// - Matching is re-enabled only when the counter reverses direction.
// - Writing the culling control register clears the culling counter.
// - Mode select 0, culling count 0, transfer culling 0 gives batch mode.
// - Batch mode compares against buffers loaded together at transfer points.
// - Phase-1 duty write arms one transfer of all seven registers.
// - Transfer points are crest at period and valley at count one.
// - A crest transfer loads the counter with new period plus one.
// - Period written while rising applies at crest, giving an asymmetric cycle.
// - Period written while falling applies at valley, keeping symmetry.
// - Duty written rising transfers at crest; written falling, at valley.
// - Mode select 0 with transfer culling 1 gives culled-transfer mode.
// - Culled mode transfers only where a culled interrupt is issued.
// - Mode select 1 is anytime mode: writes reach buffers at once.
// - Transfer request set by phase-1 write, cleared by transfer or mode 1.
module pwmcr_top #(
  parameter int unsigned DW = 16
) (
  input  wire logic          i_clk,
  input  wire logic          i_rst_b,
  input  wire logic [7:0]    i_addr,
  input  wire logic [DW-1:0] i_wdata,
  input  wire logic          i_wr,
  input  wire logic          i_rd,
  output logic      [DW-1:0] o_rdata,
  output logic      [2:0]    o_phase_positive_output,
  output logic      [2:0]    o_phase_match_irq,
  output logic               o_crest_irq,
  output logic               o_valley_irq,
  output logic      [DW-1:0] o_slave_trigger_compare0,
  output logic      [DW-1:0] o_slave_trigger_compare1
);

  // ===========================================================================
  // Software registers and their shadow buffers
  logic [DW-1:0] period_reg_ff;
  logic [DW-1:0] nxt_period_reg;
  logic [DW-1:0] period_buf_ff;
  logic [DW-1:0] nxt_period_buf;
  logic [DW-1:0] duty_reg_ff   [3];
  logic [DW-1:0] nxt_duty_reg  [3];
  logic [DW-1:0] duty_shadow_buffer_ff [3];
  logic [DW-1:0] nxt_duty_buf  [3];
  logic [6:0]    cull_reg_ff;
  logic [6:0]    nxt_cull_reg;
  logic [6:0]    cull_buf_ff;
  logic [6:0]    nxt_cull_buf;
  logic [DW-1:0] slv0_reg_ff;
  logic [DW-1:0] nxt_slv0_reg;
  logic [DW-1:0] slv1_reg_ff;
  logic [DW-1:0] nxt_slv1_reg;
  logic [DW-1:0] slv0_buf_ff;
  logic [DW-1:0] nxt_slv0_buf;
  logic [DW-1:0] slv1_buf_ff;
  logic [DW-1:0] nxt_slv1_buf;
  logic          cms_ff;
  logic          nxt_cms;
  logic          run_ff;
  logic          nxt_run;
  logic          rde_ff;
  logic          nxt_rde;
  logic          pending_ff;
  logic          nxt_pending;

  // ===========================================================================
  // Counter, events and read port
  logic [DW-1:0] cnt_ff;
  logic [DW-1:0] nxt_cnt;
  logic          dir_up_ff;
  logic          nxt_dir_up;
  logic          crest;
  logic          valley;
  logic          crest_issue;
  logic          valley_issue;
  logic          xfer_pt;
  logic          xfer;
  logic          crest_irq_ff;
  logic          valley_irq_ff;
  logic [DW-1:0] rdata_ff;
  logic [DW-1:0] nxt_rdata;
  logic          wr_cull;
  pwmcr_pkg::pwmcr_mode_type mode;

  assign o_rdata                  = rdata_ff;
  assign o_crest_irq              = crest_irq_ff;
  assign o_valley_irq             = valley_irq_ff;
  assign o_slave_trigger_compare0 = slv0_buf_ff;
  assign o_slave_trigger_compare1 = slv1_buf_ff;
  assign wr_cull = i_wr && (i_addr == `PWMCR_CULL_OFS);

  // Mode from select bit and transfer culling enable
  always_comb begin
    if (cms_ff) begin
      mode = pwmcr_pkg::PWMCR_ANYTIME;
    end else if (rde_ff) begin
      mode = pwmcr_pkg::PWMCR_CULLED;
    end else begin
      mode = pwmcr_pkg::PWMCR_BATCH;
    end
  end

  // Crest at the buffered period, valley at count one
  assign crest  = run_ff && dir_up_ff && (cnt_ff == period_buf_ff);
  assign valley = run_ff && !dir_up_ff && (cnt_ff == `PWMCR_CNT_MIN);

  // Culled mode only moves data where an interrupt survives culling
  always_comb begin
    xfer_pt = 1'b0;
    unique case (mode)
      pwmcr_pkg::PWMCR_BATCH:  xfer_pt = crest | valley;
      pwmcr_pkg::PWMCR_CULLED: xfer_pt = crest_issue | valley_issue;
      pwmcr_pkg::PWMCR_ANYTIME: xfer_pt = 1'b0;
    endcase
  end
  assign xfer = pending_ff && xfer_pt;

  // ===========================================================================
  // Interrupt culling
  pwmcr_cull u_cull (
    .i_clk          (i_clk),
    .i_rst_b        (i_rst_b),
    .i_crest        (crest),
    .i_valley       (valley),
    .i_crest_en     (cull_buf_ff[`PWMCR_ICE_BIT]),
    .i_valley_en    (cull_buf_ff[`PWMCR_IOE_BIT]),
    .i_cull_cnt     (cull_buf_ff[`PWMCR_ID_MSB:0]),
    .i_clear        (wr_cull),
    .o_crest_issue  (crest_issue),
    .o_valley_issue (valley_issue)
  );

  // ===========================================================================
  // Register writes, transfer and request flag
  always_comb begin
    nxt_period_reg = period_reg_ff;
    nxt_period_buf = period_buf_ff;
    nxt_cull_reg   = cull_reg_ff;
    nxt_cull_buf   = cull_buf_ff;
    nxt_slv0_reg   = slv0_reg_ff;
    nxt_slv1_reg   = slv1_reg_ff;
    nxt_slv0_buf   = slv0_buf_ff;
    nxt_slv1_buf   = slv1_buf_ff;
    nxt_cms        = cms_ff;
    nxt_run        = run_ff;
    nxt_rde        = rde_ff;
    nxt_pending    = pending_ff;
    for (int i = 0; i < 3; i++) begin
      nxt_duty_reg[i] = duty_reg_ff[i];
      nxt_duty_buf[i] = duty_shadow_buffer_ff[i];
    end
    // All seven buffers move in the same cycle
    if (xfer) begin
      nxt_period_buf = period_reg_ff;
      nxt_cull_buf   = cull_reg_ff;
      nxt_slv0_buf   = slv0_reg_ff;
      nxt_slv1_buf   = slv1_reg_ff;
      for (int i = 0; i < 3; i++) begin
        nxt_duty_buf[i] = duty_reg_ff[i];
      end
      nxt_pending = 1'b0;
    end
    // Writes come last so a request set beats a transfer clear
    if (i_wr) begin
      unique case (i_addr)
        `PWMCR_PERIOD_OFS: begin
          nxt_period_reg = i_wdata;
          if (cms_ff) nxt_period_buf = i_wdata;
        end
        `PWMCR_DUTY1_OFS: begin
          nxt_duty_reg[0] = i_wdata;
          if (cms_ff) nxt_duty_buf[0] = i_wdata;
          else nxt_pending = 1'b1;
        end
        `PWMCR_DUTY2_OFS: begin
          nxt_duty_reg[1] = i_wdata;
          if (cms_ff) nxt_duty_buf[1] = i_wdata;
        end
        `PWMCR_DUTY3_OFS: begin
          nxt_duty_reg[2] = i_wdata;
          if (cms_ff) nxt_duty_buf[2] = i_wdata;
        end
        `PWMCR_OPT0_OFS: begin
          nxt_cms = i_wdata[`PWMCR_CMS_BIT];
          nxt_run = i_wdata[`PWMCR_RUN_BIT];
          if (i_wdata[`PWMCR_CMS_BIT]) nxt_pending = 1'b0;
        end
        `PWMCR_CULL_OFS: begin
          nxt_cull_reg = i_wdata[`PWMCR_CULL_MSB:0];
          if (cms_ff) nxt_cull_buf = i_wdata[`PWMCR_CULL_MSB:0];
        end
        `PWMCR_OPT2_OFS: nxt_rde = i_wdata[`PWMCR_RDE_BIT];
        `PWMCR_SLV0_OFS: begin
          nxt_slv0_reg = i_wdata;
          if (cms_ff) nxt_slv0_buf = i_wdata;
        end
        `PWMCR_SLV1_OFS: begin
          nxt_slv1_reg = i_wdata;
          if (cms_ff) nxt_slv1_buf = i_wdata;
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      period_reg_ff <= `PWMCR_PERIOD_RST;
      period_buf_ff <= `PWMCR_PERIOD_RST;
      cull_reg_ff   <= `PWMCR_CULL_RST;
      cull_buf_ff   <= `PWMCR_CULL_RST;
      slv0_reg_ff   <= `PWMCR_SLV_RST;
      slv1_reg_ff   <= `PWMCR_SLV_RST;
      slv0_buf_ff   <= `PWMCR_SLV_RST;
      slv1_buf_ff   <= `PWMCR_SLV_RST;
      cms_ff        <= 1'b0;
      run_ff        <= 1'b0;
      rde_ff        <= 1'b0;
      pending_ff    <= 1'b0;
      for (int i = 0; i < 3; i++) begin
        duty_reg_ff[i]           <= `PWMCR_DUTY_RST;
        duty_shadow_buffer_ff[i] <= `PWMCR_DUTY_RST;
      end
    end else begin
      period_reg_ff <= nxt_period_reg;
      period_buf_ff <= nxt_period_buf;
      cull_reg_ff   <= nxt_cull_reg;
      cull_buf_ff   <= nxt_cull_buf;
      slv0_reg_ff   <= nxt_slv0_reg;
      slv1_reg_ff   <= nxt_slv1_reg;
      slv0_buf_ff   <= nxt_slv0_buf;
      slv1_buf_ff   <= nxt_slv1_buf;
      cms_ff        <= nxt_cms;
      run_ff        <= nxt_run;
      rde_ff        <= nxt_rde;
      pending_ff    <= nxt_pending;
      for (int i = 0; i < 3; i++) begin
        duty_reg_ff[i]           <= nxt_duty_reg[i];
        duty_shadow_buffer_ff[i] <= nxt_duty_buf[i];
      end
    end
  end

  // ===========================================================================
  // Triangular counter
  // A period below the count in anytime mode wraps through zero
  always_comb begin
    nxt_cnt    = cnt_ff;
    nxt_dir_up = dir_up_ff;
    if (!run_ff) begin
      nxt_cnt    = `PWMCR_CNT_MIN;
      nxt_dir_up = 1'b1;
    end else if (crest) begin
      nxt_dir_up = 1'b0;
      nxt_cnt    = xfer ? period_reg_ff + `PWMCR_CNT_MIN
                        : cnt_ff - `PWMCR_CNT_MIN;
    end else if (valley) begin
      nxt_dir_up = 1'b1;
      nxt_cnt    = cnt_ff + `PWMCR_CNT_MIN;
    end else begin
      nxt_cnt = dir_up_ff ? cnt_ff + `PWMCR_CNT_MIN
                          : cnt_ff - `PWMCR_CNT_MIN;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      cnt_ff        <= `PWMCR_CNT_MIN;
      dir_up_ff     <= 1'b1;
      crest_irq_ff  <= 1'b0;
      valley_irq_ff <= 1'b0;
    end else begin
      cnt_ff        <= nxt_cnt;
      dir_up_ff     <= nxt_dir_up;
      crest_irq_ff  <= crest_issue;
      valley_irq_ff <= valley_issue;
    end
  end

  // ===========================================================================
  // Phases
  for (genvar g = 0; g < 3; g++) begin : g_phase
    pwmcr_phase #(
      .DW (DW)
    ) u_phase (
      .i_clk       (i_clk),
      .i_rst_b     (i_rst_b),
      .i_run       (run_ff),
      .i_cnt       (cnt_ff),
      .i_dir_up    (dir_up_ff),
      .i_duty      (duty_shadow_buffer_ff[g]),
      .i_crest     (crest),
      .i_valley    (valley),
      .o_pos       (o_phase_positive_output[g]),
      .o_match_irq (o_phase_match_irq[g])
    );
  end

  // ===========================================================================
  // Read port, data one cycle after the strobe, zero otherwise
  always_comb begin
    nxt_rdata = '0;
    if (i_rd) begin
      unique case (i_addr)
        `PWMCR_PERIOD_OFS: nxt_rdata = period_reg_ff;
        `PWMCR_DUTY1_OFS:  nxt_rdata = duty_reg_ff[0];
        `PWMCR_DUTY2_OFS:  nxt_rdata = duty_reg_ff[1];
        `PWMCR_DUTY3_OFS:  nxt_rdata = duty_reg_ff[2];
        `PWMCR_OPT0_OFS: begin
          nxt_rdata[`PWMCR_CMS_BIT] = cms_ff;
          nxt_rdata[`PWMCR_RUN_BIT] = run_ff;
        end
        `PWMCR_CULL_OFS:   nxt_rdata = DW'(cull_reg_ff);
        `PWMCR_OPT2_OFS:   nxt_rdata[`PWMCR_RDE_BIT] = rde_ff;
        `PWMCR_SLV0_OFS:   nxt_rdata = slv0_reg_ff;
        `PWMCR_SLV1_OFS:   nxt_rdata = slv1_reg_ff;
        `PWMCR_CNT_OFS:    nxt_rdata = cnt_ff;
        `PWMCR_STAT_OFS: begin
          nxt_rdata[`PWMCR_ST_RUN]  = run_ff;
          nxt_rdata[`PWMCR_ST_UP]   = dir_up_ff;
          nxt_rdata[`PWMCR_ST_PEND] = pending_ff;
        end
        default: nxt_rdata = '0;
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      rdata_ff <= '0;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  // ===========================================================================
  // Checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);

  chk_req_set: assert property (
    i_wr && i_addr == `PWMCR_DUTY1_OFS && !cms_ff |=> pending_ff)
    else $error("phase-1 write did not arm a transfer");
  chk_req_mode_clr: assert property (
    i_wr && i_addr == `PWMCR_OPT0_OFS && i_wdata[0] |=> !pending_ff)
    else $error("anytime select did not drop the request");
  chk_batch_copy: assert property (
    xfer && !i_wr |=> period_buf_ff == $past(period_reg_ff) && !pending_ff
    && duty_shadow_buffer_ff[2] == $past(duty_reg_ff[2]))
    else $error("transfer did not copy the buffers together");
  chk_no_req_hold: assert property (
    !pending_ff && !cms_ff |=> $stable(duty_shadow_buffer_ff[0]))
    else $error("buffer moved without a transfer request");
  chk_crest_load: assert property (
    crest && xfer |=> cnt_ff == DW'($past(period_reg_ff) + 1'b1))
    else $error("crest transfer did not load period plus one");
  chk_culled_skip: assert property (
    mode == pwmcr_pkg::PWMCR_CULLED && pending_ff && (crest || valley)
    && !crest_issue && !valley_issue && !i_wr |=> pending_ff)
    else $error("culled-away point caused a transfer");
  chk_anytime_now: assert property (
    cms_ff && i_wr && i_addr == `PWMCR_DUTY1_OFS
    |=> duty_shadow_buffer_ff[0] == $past(i_wdata))
    else $error("anytime write did not reach the buffer");
  chk_turn_crest: assert property (
    crest |=> !dir_up_ff ##1 (!dir_up_ff || $past(valley)))
    else $error("counter did not turn down at crest");
  chk_batch_point: assert property (
    mode == pwmcr_pkg::PWMCR_BATCH && pending_ff && valley && !i_wr
    |=> !pending_ff)
    else $error("valley was not a batch transfer point");

  cov_batch_xfer: cover property (mode == pwmcr_pkg::PWMCR_BATCH && xfer);
  cov_cull_xfer: cover property (mode == pwmcr_pkg::PWMCR_CULLED && xfer);
  cov_crest_load: cover property (crest && xfer);
  cov_valley: cover property (valley ##[1:600] crest);

endmodule : pwmcr_top

/* pwmcr_map.svh */
// Register offsets, field positions and reset values of the PWM reload block
`ifndef PWMCR_MAP_SVH
`define PWMCR_MAP_SVH

// ===========================================================================
// Register byte offsets
`define PWMCR_PERIOD_OFS 8'h00
`define PWMCR_DUTY1_OFS  8'h04
`define PWMCR_DUTY2_OFS  8'h08
`define PWMCR_DUTY3_OFS  8'h0C
`define PWMCR_OPT0_OFS   8'h10
`define PWMCR_CULL_OFS   8'h14
`define PWMCR_OPT2_OFS   8'h18
`define PWMCR_SLV0_OFS   8'h1C
`define PWMCR_SLV1_OFS   8'h20
`define PWMCR_CNT_OFS    8'h24
`define PWMCR_STAT_OFS   8'h28

// ===========================================================================
// Field positions
`define PWMCR_CMS_BIT    0
`define PWMCR_RUN_BIT    1
`define PWMCR_RDE_BIT    0
`define PWMCR_ID_MSB     4
`define PWMCR_IOE_BIT    5
`define PWMCR_ICE_BIT    6
`define PWMCR_CULL_MSB   6
`define PWMCR_ST_RUN     0
`define PWMCR_ST_UP      1
`define PWMCR_ST_PEND    2

// ===========================================================================
// Reset values and counter constants
`define PWMCR_PERIOD_RST 16'h0100
`define PWMCR_DUTY_RST   16'h0000
`define PWMCR_SLV_RST    16'h0000
`define PWMCR_CULL_RST   7'h60
`define PWMCR_CNT_MIN    16'h0001
`define PWMCR_ID_ZERO    5'h00

`endif

/* pwmcr_pkg.sv */
// Types shared by the PWM reload block
package pwmcr_pkg;

  // ===========================================================================
  // Rewrite modes
  typedef enum logic [2:0] {
    PWMCR_ANYTIME = 3'b001,
    PWMCR_BATCH   = 3'b010,
    PWMCR_CULLED  = 3'b100
  } pwmcr_mode_type;

endpackage : pwmcr_pkg

/* pwmcr_cull.sv */
// Crest and valley interrupt culling counter
`include "pwmcr_map.svh"

module pwmcr_cull (
  input  wire logic       i_clk,
  input  wire logic       i_rst_b,
  input  wire logic       i_crest,
  input  wire logic       i_valley,
  input  wire logic       i_crest_en,
  input  wire logic       i_valley_en,
  input  wire logic [4:0] i_cull_cnt,
  input  wire logic       i_clear,
  output logic            o_crest_issue,
  output logic            o_valley_issue
);

  // ===========================================================================
  // Counting of enabled events
  logic [4:0] seen_ff;
  logic [4:0] nxt_seen;
  logic       evt;
  logic       hit;

  // An event is issued once the skipped count has reached the setting
  assign evt = (i_crest & i_crest_en) | (i_valley & i_valley_en);
  assign hit = evt && (seen_ff == i_cull_cnt);
  assign o_crest_issue  = hit & i_crest;
  assign o_valley_issue = hit & i_valley;

  // A control write throws away what was counted so far
  always_comb begin
    nxt_seen = seen_ff;
    if (i_clear) begin
      nxt_seen = `PWMCR_ID_ZERO;
    end else if (evt) begin
      nxt_seen = hit ? `PWMCR_ID_ZERO : seen_ff + 5'h01;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      seen_ff <= `PWMCR_ID_ZERO;
    end else begin
      seen_ff <= nxt_seen;
    end
  end

  // ===========================================================================
  // Checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);

  chk_cull_clear: assert property (i_clear |=> seen_ff == 5'h00)
    else $error("culling count not cleared by control write");

endmodule : pwmcr_cull

/* pwmcr_phase.sv */
// One PWM phase: duty match, match enable and positive output
module pwmcr_phase #(
  parameter int unsigned DW = 16
) (
  input  wire logic          i_clk,
  input  wire logic          i_rst_b,
  input  wire logic          i_run,
  input  wire logic [DW-1:0] i_cnt,
  input  wire logic          i_dir_up,
  input  wire logic [DW-1:0] i_duty,
  input  wire logic          i_crest,
  input  wire logic          i_valley,
  output logic               o_pos,
  output logic               o_match_irq
);

  // ===========================================================================
  // Match detection and output state
  logic eq;
  logic match_edge;
  logic eq_ff;
  logic armed_ff;
  logic pos_ff;
  logic irq_ff;
  logic nxt_armed;
  logic nxt_pos;

  // Edge of equality, so a stalled compare raises only one match
  assign eq         = i_run && (i_cnt == i_duty);
  assign match_edge = eq && !eq_ff;
  assign o_pos       = pos_ff;
  assign o_match_irq = irq_ff;

  // Crest and valley force the level, so no duty value gives 0 % or 100 % duty
  always_comb begin
    nxt_pos   = pos_ff;
    nxt_armed = armed_ff;
    if (i_valley) begin
      nxt_pos = 1'b0;
    end else if (i_crest) begin
      nxt_pos = 1'b1;
    end else if (match_edge && armed_ff) begin
      nxt_pos = i_dir_up;
    end
    if (i_crest || i_valley) begin
      nxt_armed = 1'b1;
    end else if (match_edge) begin
      nxt_armed = 1'b0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      eq_ff    <= 1'b0;
      armed_ff <= 1'b1;
      pos_ff   <= 1'b0;
      irq_ff   <= 1'b0;
    end else begin
      eq_ff    <= eq;
      armed_ff <= nxt_armed;
      pos_ff   <= nxt_pos;
      irq_ff   <= match_edge;
    end
  end

  // ===========================================================================
  // Checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);

  chk_crest_high: assert property (i_crest && !i_valley |=> pos_ff)
    else $error("positive output not high after crest");
  chk_valley_low: assert property (i_valley |=> !pos_ff)
    else $error("positive output not low after valley");
  chk_ignored_match: assert property (
    match_edge && !armed_ff && !i_crest && !i_valley |=> $stable(pos_ff))
    else $error("second match in one slope changed the output");
  chk_irq_on_match: assert property (match_edge |=> irq_ff ##1 !irq_ff)
    else $error("match interrupt not a single pulse");
  chk_rearm_turn: assert property (
    i_crest || i_valley |=> armed_ff)
    else $error("match not re-enabled after reversal");
  cov_ignored: cover property (match_edge && !armed_ff);

endmodule : pwmcr_phase

/* pwmcr_gate_model.sv */
// Gate driver stand-in that counts turn-on edges of the phase-1 high side
module pwmcr_gate_model (
  input  wire logic       i_clk,
  input  wire logic       i_rst_b,
  input  wire logic [2:0] i_pos,
  output logic      [7:0] o_rise1
);
  logic       pos_ff;
  logic [7:0] rise_ff;
  logic [7:0] nxt_rise;
  // ==========
  // Edge count; a toggling bug shows up as extra turn-ons
  always_comb begin
    nxt_rise = rise_ff + {7'h00, i_pos[0] & ~pos_ff};
  end
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      pos_ff  <= 1'b0;
      rise_ff <= 8'h00;
    end else begin
      pos_ff  <= i_pos[0];
      rise_ff <= nxt_rise;
    end
  end
  assign o_rise1 = rise_ff;
endmodule : pwmcr_gate_model

/* pwmcr_top_tb.sv */
// Self-checking bench for the PWM compare reload block
`include "pwmcr_map.svh"
module pwmcr_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [15:0] P = 16'h0010;
  logic        i_clk;
  logic        i_rst_b;
  logic [7:0]  i_addr;
  logic [15:0] i_wdata;
  logic        i_wr;
  logic        i_rd;
  logic [15:0] o_rdata;
  logic [2:0]  o_pos;
  logic [2:0]  o_mirq;
  logic        o_crest;
  logic        o_valley;
  logic [15:0] o_slv0;
  logic [15:0] o_slv1;
  logic [7:0]  rise1;
  logic [15:0] d;
  int          n_mismatch;
  int          compares;
  int          n;
  int          k;
  int          m;
  // ==========
  // Block and gate driver
  pwmcr_top #(.DW(16)) i_pwmcr_top (.i_clk(i_clk), .i_rst_b(i_rst_b),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
    .o_rdata(o_rdata), .o_phase_positive_output(o_pos),
    .o_phase_match_irq(o_mirq), .o_crest_irq(o_crest),
    .o_valley_irq(o_valley), .o_slave_trigger_compare0(o_slv0),
    .o_slave_trigger_compare1(o_slv1));
  pwmcr_gate_model i_pwmcr_gate_model (.i_clk(i_clk), .i_rst_b(i_rst_b),
    .i_pos(o_pos), .o_rise1(rise1));
  // ==========
  // Shared tasks
  task automatic chk(input string s, input logic [15:0] e, logic [15:0] g);
    compares++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", s, e, g);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [15:0] v);
    @(posedge i_clk);
    i_addr  <= a;
    i_wdata <= v;
    i_wr    <= 1'b1;
    @(posedge i_clk);
    i_wr    <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [15:0] v);
    @(posedge i_clk);
    i_addr <= a;
    i_rd   <= 1'b1;
    @(posedge i_clk);
    i_rd   <= 1'b0;
    @(posedge i_clk);
    v = o_rdata;
  endtask : rd
  // Bounded wait: 0 crest, 1 valley, 2 either; cycles back in c
  task automatic wt(input int w, output int c);
    c = 0;
    do begin
      @(posedge i_clk);
      c++;
    end while (!((w != 1 && o_crest === 1'b1) ||
                 (w != 0 && o_valley === 1'b1)) && c < 600);
    if (c >= 600) chk("irq wait", 16'h0000, 16'h0001);
  endtask : wt
  task automatic fall(output int c);
    c = 0;
    do begin
      @(posedge i_clk);
      c++;
    end while (o_pos[0] !== 1'b0 && c < 100);
  endtask : fall
  task automatic final_report;
    if (n_mismatch == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : final_report
  // ==========
  // Scenarios
  task t_reset;
    rd(`PWMCR_PERIOD_OFS, d);
    chk("period", `PWMCR_PERIOD_RST, d);
    rd(`PWMCR_CULL_OFS, d);
    chk("cull ctrl", {9'h000, `PWMCR_CULL_RST}, d);
    rd(`PWMCR_STAT_OFS, d);
    chk("status", 16'h0002, d);
    rd(8'h30, d);
    chk("unmapped", 16'h0000, d);
  endtask : t_reset
  // Batch load of seven buffers at the first crest
  task t_batch;
    wr(`PWMCR_OPT0_OFS, 16'h0002);
    wr(`PWMCR_PERIOD_OFS, P);
    wr(`PWMCR_SLV0_OFS, 16'h1234);
    wr(`PWMCR_DUTY1_OFS, 16'h0008);
    rd(`PWMCR_STAT_OFS, d);
    chk("armed", 16'h0007, d);
    chk("slave0 held", 16'h0000, o_slv0);
    wt(0, n);
    chk("slave0 loaded", 16'h1234, o_slv0);
    rd(`PWMCR_CNT_OFS, d);
    chk("crest reload", P + 16'h0001 - 16'h0002, d);
    rd(`PWMCR_STAT_OFS, d);
    chk("request done", 16'h0001, d);
  endtask : t_batch
  task t_tri;
    wt(1, n);
    chk("valley outs", 16'h0000, {13'h0000, o_pos});
    wt(1, n);
    chk("valley spacing", 2 * (P - 16'h0001), n[15:0]);
    wt(0, n);
    chk("crest outs", 16'h0007, {13'h0000, o_pos});
    // Shorter period written while falling moves at the valley
    wr(`PWMCR_PERIOD_OFS, 16'h000C);
    wr(`PWMCR_DUTY1_OFS, 16'h0008);
    wt(1, n);
    wt(1, n);
    chk("short spacing", 16'h0002 * (16'h000C - 16'h0001), n[15:0]);
    // Period restored on a rising slope, applied at the crest
    wr(`PWMCR_PERIOD_OFS, P);
    wr(`PWMCR_DUTY1_OFS, 16'h0008);
    wt(0, n);
  endtask : t_tri
  // Anytime rewrite on the falling slope: reached and never reached
  task t_any;
    wr(`PWMCR_OPT0_OFS, 16'h0003);
    wr(`PWMCR_DUTY1_OFS, 16'h0008);
    wr(`PWMCR_SLV1_OFS, 16'h00AB);
    @(posedge i_clk);
    chk("slave1 direct", 16'h00AB, o_slv1);
    rd(`PWMCR_STAT_OFS, d);
    chk("no request", 16'h0000, d & 16'h0004);
    for (k = 0; k < 2; k++) begin
      wt(0, n);
      wr(`PWMCR_DUTY1_OFS, (k == 0) ? 16'h0004 : 16'h0020);
      fall(n);
      chk("fall delay", (k == 0) ? P - 16'h0006 : P - 16'h0003, n[15:0]);
    end
  endtask : t_any
  // Second match on a rising slope is ignored but still interrupts
  task t_rise;
    wt(1, n);
    k = rise1;
    wr(`PWMCR_DUTY1_OFS, 16'h0006);
    wr(`PWMCR_DUTY1_OFS, 16'h000A);
    m = 0;
    repeat (10) begin
      @(posedge i_clk);
      m += (o_mirq[0] === 1'b1);
    end
    wt(0, n);
    chk("match irqs", 16'h0002, m[15:0]);
    chk("turn-ons", 16'h0001, {8'h00, rise1 - k[7:0]});
    fall(n);
    chk("rearmed fall", P - 16'h000A, n[15:0]);
  endtask : t_rise
  task t_cull;
    wr(`PWMCR_OPT0_OFS, 16'h0002);
    wr(`PWMCR_OPT2_OFS, 16'h0001);
    wr(`PWMCR_CULL_OFS, 16'h0061);
    wr(`PWMCR_SLV1_OFS, 16'h0055);
    wr(`PWMCR_DUTY1_OFS, 16'h000A);
    wt(2, n);
    chk("culled load", 16'h0055, o_slv1);
    wt(2, n);
    wt(2, n);
    chk("culled spacing", 2 * (P - 16'h0001), n[15:0]);
    repeat (20) @(posedge i_clk);
    wr(`PWMCR_CULL_OFS, 16'h0061);
    wr(`PWMCR_SLV1_OFS, 16'h0066);
    wr(`PWMCR_DUTY1_OFS, 16'h000A);
    wt(2, n);
    chk("culling restart", 3 * (P - 16'h0001) - 16'h001A, n[15:0]);
    chk("culled reload", 16'h0066, o_slv1);
  endtask : t_cull
  // ==========
  // Clock, watchdog and main sequence
  initial begin
    i_clk = 1'b0;
    forever #4 i_clk = ~i_clk;
  end
  initial begin
    repeat (5000) @(posedge i_clk);
    n_mismatch++;
    final_report;
  end
  initial begin
    i_rst_b = 1'b0;
    i_addr = 8'h00;
    i_wdata = 16'h0000;
    i_wr = 1'b0;
    i_rd = 1'b0;
    n_mismatch = 0;
    compares = 0;
    repeat (2) @(posedge i_clk);
    i_rst_b <= 1'b1;
    t_reset;
    t_batch;
    t_tri;
    t_any;
    t_rise;
    t_cull;
    final_report;
  end
endmodule : pwmcr_top_tb
